// *** logic/gftc_byte_swap.sv ***
`timescale 1ns/1ps
`default_nettype none
module gftc_byte_swap (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [31:0] in_data,
  input wire logic in_is_data_section,
  input wire logic data_byte_order_select,
  output logic out_valid,
  output logic [31:0] out_data
);
  import gftc_pkg::*;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } gftc_bs_state_t;

  gftc_bs_state_t s;
  gftc_bs_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.valid = in_valid;
    if (in_valid) begin
      // registers, vectors and descriptors pass untouched
      if (in_is_data_section && data_byte_order_select) begin
        next_s.data = {in_data[7:0], in_data[15:8], in_data[23:16], in_data[31:24]};
      end else begin
        next_s.data = in_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign out_valid = s.valid;
  assign out_data = s.data;
endmodule
`default_nettype wire

// *** logic/gftc_short_frame.sv ***
`timescale 1ns/1ps
`default_nettype none
module gftc_short_frame (
  input wire logic clk,
  input wire logic rst,
  input wire logic frame_end,
  input wire logic [gftc_pkg::GFTC_LEN_W-1:0] frame_len,
  input wire logic frame_crc32,
  input wire logic short_frame_length_select,
  output logic done,
  output logic is_short
);
  import gftc_pkg::*;

  typedef struct packed {
    logic done;
    logic is_short;
  } gftc_sf_state_t;

  gftc_sf_state_t s;
  gftc_sf_state_t next_s;
  logic [GFTC_LEN_W-1:0] limit;

  always_comb begin
    next_s = s;
    next_s.done = frame_end;
    // one global select sets the limit for every channel
    if (short_frame_length_select) begin
      limit = frame_crc32 ? GFTC_SHORT_CRC32_ALT : GFTC_SHORT_CRC16_ALT;
    end else begin
      limit = frame_crc32 ? GFTC_SHORT_CRC32_STD : GFTC_SHORT_CRC16_STD;
    end
    if (frame_end) begin
      next_s.is_short = frame_len < limit;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign is_short = s.is_short;
endmodule
`default_nettype wire

// *** logic/gftc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module gftc_top #(
  parameter int NUM_PORTS = 28
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [gftc_pkg::GFTC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [gftc_pkg::GFTC_DATA_W-1:0] avs_writedata,
  input wire logic [gftc_pkg::GFTC_BE_W-1:0] avs_byteenable,
  output logic [gftc_pkg::GFTC_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic free_pool_valid,
  input wire logic [gftc_pkg::GFTC_POOL_W-1:0] free_pool_count,
  input wire logic rx_frame_end,
  input wire logic [gftc_pkg::GFTC_LEN_W-1:0] rx_frame_len,
  input wire logic rx_frame_crc32,
  output logic short_frame_done,
  output logic short_frame_flag,
  input wire logic dma_valid,
  input wire logic [31:0] dma_data,
  input wire logic dma_is_data_section,
  output logic dma_out_valid,
  output logic [31:0] dma_out_data,
  input wire logic vec_req,
  input wire logic vec_is_port,
  output logic vec_queue_valid,
  output logic [gftc_pkg::GFTC_QSEL_W-1:0] vec_queue,
  input wire logic [NUM_PORTS-1:0] port_pin_in,
  input wire logic [NUM_PORTS-1:0] port_out_int,
  input wire logic [NUM_PORTS-1:0] port_oe_int,
  output logic [NUM_PORTS-1:0] port_pin_out,
  output logic [NUM_PORTS-1:0] port_pin_oe,
  input wire logic test_pin_in,
  output logic test_pin_out,
  output logic test_pin_oe,
  input wire logic port0_tx_clk_in,
  input wire logic port0_unchannelized,
  output logic tx_clock_out_pin,
  output logic tx_clock_out_pin_oe,
  input wire logic rx_chan_valid,
  input wire logic [gftc_pkg::GFTC_CHAN_W-1:0] rx_chan_id,
  input wire logic [7:0] rx_chan_data,
  input wire logic tx_chan_req,
  input wire logic [gftc_pkg::GFTC_CHAN_W-1:0] tx_chan_id,
  output logic tx_loop_valid,
  output logic [7:0] tx_loop_data
);
  import gftc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic waitrq;
    logic [GFTC_DATA_W-1:0] rdata;
    logic [GFTC_FRAME_CFG_W-1:0] frame_cfg;
    logic [31:0] queue_cfg;
    logic [GFTC_POOL_W-1:0] rb_thresh;
    logic [GFTC_IRQ_W-1:0] status;
    logic [GFTC_IRQ_W-1:0] mask;
    logic irq;
    logic below_q;
    logic vec_valid;
    logic [GFTC_QSEL_W-1:0] vec_q;
    logic [NUM_PORTS-1:0] port_sync1;
    logic [NUM_PORTS-1:0] port_sync2;
    logic test_sync1;
    logic test_sync2;
    logic tclk_sync1;
    logic tclk_sync2;
    logic [NUM_PORTS-1:0] port_out;
    logic [NUM_PORTS-1:0] port_oe;
    logic test_out;
    logic test_oe;
    logic tclk_out;
    logic tclk_oe;
    logic loop_full;
    logic [7:0] loop_data;
    logic tx_valid;
    logic [7:0] tx_data;
  } gftc_state_t;

  gftc_state_t s;
  gftc_state_t next_s;

  function automatic logic [31:0] gftc_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // configuration fields

  logic short_frame_length_select;
  logic rx_buffer_monitor_select;
  logic data_byte_order_select;
  logic [GFTC_QSEL_W-1:0] system_vector_queue_select;
  logic [GFTC_QSEL_W-1:0] port_vector_queue_select;
  logic test_breakout_enable;
  logic tx_clock_out_disable;
  logic remote_channel_loop_enable;
  logic [GFTC_PORT_SEL_W-1:0] test_port_select;
  logic [GFTC_CHAN_W-1:0] loop_channel_select;

  assign short_frame_length_select = s.frame_cfg[GFTC_BIT_SHORT_LEN];
  assign rx_buffer_monitor_select = s.frame_cfg[GFTC_BIT_RB_MON];
  assign data_byte_order_select = s.frame_cfg[GFTC_BIT_BYTE_ORDER];
  assign system_vector_queue_select = s.queue_cfg[GFTC_SYSTEM_VECTOR_QUEUE_SELECT_LSB +: GFTC_QSEL_W];
  assign port_vector_queue_select = s.queue_cfg[GFTC_PORT_VECTOR_QUEUE_SELECT_LSB +: GFTC_QSEL_W];
  assign test_breakout_enable = s.queue_cfg[GFTC_TEST_EN_BIT];
  assign tx_clock_out_disable = s.queue_cfg[GFTC_TXCLK_DIS_BIT];
  assign remote_channel_loop_enable = s.queue_cfg[GFTC_LOOP_EN_BIT];
  assign test_port_select = s.queue_cfg[GFTC_TEST_PORT_LSB +: GFTC_PORT_SEL_W];
  assign loop_channel_select = s.queue_cfg[GFTC_LOOP_CHAN_LSB +: GFTC_CHAN_W];

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // one select shared by every channel's classifier
  gftc_short_frame u_short_frame (
    .clk(clk),
    .rst(rst),
    .frame_end(rx_frame_end),
    .frame_len(rx_frame_len),
    .frame_crc32(rx_frame_crc32),
    .short_frame_length_select(short_frame_length_select),
    .done(short_frame_done),
    .is_short(short_frame_flag)
  );

  gftc_byte_swap u_byte_swap (
    .clk(clk),
    .rst(rst),
    .in_valid(dma_valid),
    .in_data(dma_data),
    .in_is_data_section(dma_is_data_section),
    .data_byte_order_select(data_byte_order_select),
    .out_valid(dma_out_valid),
    .out_data(dma_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // per-port breakout muxing

  logic [NUM_PORTS-1:0] port_out_mux;
  logic [NUM_PORTS-1:0] port_oe_mux;
  logic test_out_mux;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      logic hit;
      assign hit = test_breakout_enable && (test_port_select == GFTC_PORT_SEL_W'(gi));
      // breakout wins over the port's own mode driven enable
      assign port_out_mux[gi] = hit ? s.test_sync2 : port_out_int[gi];
      assign port_oe_mux[gi] = hit ? 1'b1 : port_oe_int[gi];
    end
  endgenerate

  // a select beyond the last port leaves the test output low
  assign test_out_mux = (32'(test_port_select) < NUM_PORTS) ?
                        s.port_sync2[test_port_select] : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic hit_rd;
  logic hit_wr;
  logic pool_below;
  logic [GFTC_IRQ_W-1:0] ev;
  logic [31:0] wval;

  always_comb begin
    next_s = s;
    hit_rd = avs_read && s.waitrq;
    hit_wr = avs_write && !s.waitrq;
    pool_below = 1'b0;
    ev = '0;
    wval = 32'h0000_0000;

    // bus: one wait cycle, then waitrequest drops for exactly one cycle
    next_s.waitrq = 1'b1;
    if ((avs_read || avs_write) && s.waitrq) begin
      next_s.waitrq = 1'b0;
    end
    if (hit_rd) begin
      case (avs_address)
        GFTC_OFS_FRAME_CFG: next_s.rdata = 32'(s.frame_cfg);
        GFTC_OFS_QUEUE_TEST: next_s.rdata = s.queue_cfg & GFTC_QUEUE_TEST_MASK;
        GFTC_OFS_RB_THRESH: next_s.rdata = 32'(s.rb_thresh);
        GFTC_OFS_IRQ_STATUS: next_s.rdata = 32'(s.status);
        GFTC_OFS_IRQ_MASK: next_s.rdata = 32'(s.mask);
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end

    if (hit_wr) begin
      case (avs_address)
        GFTC_OFS_FRAME_CFG: begin
          wval = gftc_merge(32'(s.frame_cfg), avs_writedata, avs_byteenable);
          next_s.frame_cfg = wval[GFTC_FRAME_CFG_W-1:0];
        end
        GFTC_OFS_QUEUE_TEST: begin
          wval = gftc_merge(s.queue_cfg, avs_writedata, avs_byteenable);
          next_s.queue_cfg = wval & GFTC_QUEUE_TEST_MASK;
        end
        GFTC_OFS_RB_THRESH: begin
          wval = gftc_merge(32'(s.rb_thresh), avs_writedata, avs_byteenable);
          next_s.rb_thresh = wval[GFTC_POOL_W-1:0];
        end
        GFTC_OFS_IRQ_STATUS: begin
          wval = avs_writedata & {{24{1'b0}}, {8{avs_byteenable[0]}}};
          next_s.status = s.status & ~wval[GFTC_IRQ_W-1:0];
        end
        GFTC_OFS_IRQ_MASK: begin
          wval = gftc_merge(32'(s.mask), avs_writedata, avs_byteenable);
          next_s.mask = wval[GFTC_IRQ_W-1:0];
        end
        default: begin
          next_s.status = s.status;
        end
      endcase
    end

    // rx buffer monitor; a software write to the threshold goes first
    if (free_pool_valid) begin
      pool_below = free_pool_count < s.rb_thresh;
      if (!rx_buffer_monitor_select) begin
        if (free_pool_count < next_s.rb_thresh) begin
          next_s.rb_thresh = free_pool_count;
        end
      end
      next_s.below_q = pool_below;
    end
    // only the crossing raises the event, not every sample below
    ev[GFTC_IRQ_RB_BELOW] = rx_buffer_monitor_select && pool_below && !s.below_q;
    ev[GFTC_IRQ_SHORT] = short_frame_done && short_frame_flag;
    // a new event beats a clear in the same cycle
    next_s.status = next_s.status | ev;
    next_s.irq = |(next_s.status & next_s.mask);

    // vector queue routing
    next_s.vec_valid = vec_req;
    if (vec_req) begin
      next_s.vec_q = vec_is_port ? port_vector_queue_select
                                 : system_vector_queue_select;
    end

    // pin synchronisers
    next_s.port_sync1 = port_pin_in;
    next_s.port_sync2 = s.port_sync1;
    next_s.test_sync1 = test_pin_in;
    next_s.test_sync2 = s.test_sync1;
    next_s.tclk_sync1 = port0_tx_clk_in;
    next_s.tclk_sync2 = s.tclk_sync1;

    // port and test pins; internal rx/tx enables are software's business
    next_s.port_out = port_out_mux;
    next_s.port_oe = port_oe_mux;
    next_s.test_out = test_out_mux;
    next_s.test_oe = test_breakout_enable;

    // the resampled clock carries three cycles of lag and jitter of one cycle
    next_s.tclk_out = port0_unchannelized ? s.tclk_sync2 : 1'b0;
    next_s.tclk_oe = !tx_clock_out_disable ||
                     (test_breakout_enable && test_port_select == GFTC_PORT_SEL_W'(0));

    // remote channel loop through a single-byte buffer
    next_s.tx_valid = 1'b0;
    if (!remote_channel_loop_enable) begin
      next_s.loop_full = 1'b0;
    end else begin
      if (tx_chan_req && tx_chan_id == loop_channel_select) begin
        next_s.tx_valid = 1'b1;
        next_s.tx_data = s.loop_full ? s.loop_data : GFTC_LOOP_IDLE;
        next_s.loop_full = 1'b0;
      end
      if (rx_chan_valid && rx_chan_id == loop_channel_select) begin
        next_s.loop_full = 1'b1;
        next_s.loop_data = rx_chan_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.waitrq <= 1'b1;
      s.frame_cfg <= GFTC_FRAME_CFG_RST;
      s.queue_cfg <= GFTC_QUEUE_TEST_RST;
      s.rb_thresh <= GFTC_RB_THRESH_RST;
      // disable bit resets to 0, so the clock pin is driven from reset on
      s.tclk_oe <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitrq;
  assign irq = s.irq;
  assign vec_queue_valid = s.vec_valid;
  assign vec_queue = s.vec_q;
  assign port_pin_out = s.port_out;
  assign port_pin_oe = s.port_oe;
  assign test_pin_out = s.test_out;
  assign test_pin_oe = s.test_oe;
  assign tx_clock_out_pin = s.tclk_out;
  assign tx_clock_out_pin_oe = s.tclk_oe;
  assign tx_loop_valid = s.tx_valid;
  assign tx_loop_data = s.tx_data;
endmodule
`default_nettype wire

// *** pkg/gftc_pkg.sv ***
package gftc_pkg;
  // bus geometry
  localparam int GFTC_DATA_W = 32;
  localparam int GFTC_ADDR_W = 8;
  localparam int GFTC_BE_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] GFTC_OFS_FRAME_CFG = 8'h40;
  localparam logic [7:0] GFTC_OFS_QUEUE_TEST = 8'h44;
  localparam logic [7:0] GFTC_OFS_RB_THRESH = 8'h70;
  localparam logic [7:0] GFTC_OFS_IRQ_STATUS = 8'h74;
  localparam logic [7:0] GFTC_OFS_IRQ_MASK = 8'h78;

  ////////////////////////////////////////////////////////////////////////////
  // frame configuration register fields
  localparam int GFTC_FRAME_CFG_W = 3;
  localparam int GFTC_BIT_SHORT_LEN = 0;
  localparam int GFTC_BIT_RB_MON = 1;
  localparam int GFTC_BIT_BYTE_ORDER = 2;
  localparam logic [2:0] GFTC_FRAME_CFG_RST = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt_queue_and_test_config fields
  localparam int GFTC_QSEL_W = 3;
  localparam int GFTC_PORT_SEL_W = 5;
  localparam int GFTC_CHAN_W = 8;
  localparam int GFTC_SYSTEM_VECTOR_QUEUE_SELECT_LSB = 28;
  localparam int GFTC_PORT_VECTOR_QUEUE_SELECT_LSB = 24;
  localparam int GFTC_TEST_EN_BIT = 22;
  localparam int GFTC_TXCLK_DIS_BIT = 21;
  localparam int GFTC_LOOP_EN_BIT = 15;
  localparam int GFTC_TEST_PORT_LSB = 8;
  localparam int GFTC_LOOP_CHAN_LSB = 0;
  localparam logic [31:0] GFTC_QUEUE_TEST_MASK = 32'h7760_9FFF;
  localparam logic [31:0] GFTC_QUEUE_TEST_RST = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // rx buffer monitor and interrupts
  localparam int GFTC_POOL_W = 16;
  localparam logic [15:0] GFTC_RB_THRESH_RST = 16'hFFFF;
  localparam int GFTC_IRQ_W = 2;
  localparam int GFTC_IRQ_RB_BELOW = 0;
  localparam int GFTC_IRQ_SHORT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // short frame limits in bytes
  localparam int GFTC_LEN_W = 16;
  localparam logic [15:0] GFTC_SHORT_CRC16_STD = 16'h0004;
  localparam logic [15:0] GFTC_SHORT_CRC32_STD = 16'h0006;
  localparam logic [15:0] GFTC_SHORT_CRC16_ALT = 16'h0002;
  localparam logic [15:0] GFTC_SHORT_CRC32_ALT = 16'h0004;

  // value sent by the loop when the loop buffer holds nothing
  localparam logic [7:0] GFTC_LOOP_IDLE = 8'hFF;
endpackage

// *** tb/gftc_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module gftc_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic rx_frame_end,
  input wire logic [gftc_pkg::GFTC_LEN_W-1:0] rx_frame_len,
  input wire logic short_frame_done,
  input wire logic short_frame_flag,
  input wire logic dma_valid,
  input wire logic [31:0] dma_data,
  input wire logic dma_is_data_section,
  input wire logic [31:0] dma_out_data,
  input wire logic vec_req,
  input wire logic vec_queue_valid,
  input wire logic tx_chan_req,
  input wire logic tx_loop_valid,
  input wire logic test_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  AST_BUS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_DONE_CAUSE: assert property (short_frame_done |-> $past(rx_frame_end))
    else $error("frame done without a frame end");
  AST_SHORT_TINY: assert property (rx_frame_end && rx_frame_len < 16'h0002 |=> short_frame_done && short_frame_flag)
    else $error("frame under two bytes not short");
  AST_SHORT_LONG: assert property (rx_frame_end && rx_frame_len >= 16'h0006 |=> !short_frame_flag)
    else $error("frame of six bytes or more marked short");
  AST_NO_SWAP: assert property (dma_valid && !dma_is_data_section |=> dma_out_data == $past(dma_data))
    else $error("non data word altered");
  AST_VEC_ANSWER: assert property (vec_req |=> vec_queue_valid)
    else $error("vector not queued");
  AST_LOOP_CAUSE: assert property (tx_loop_valid |-> $past(tx_chan_req))
    else $error("loop byte without a request");
  AST_BREAKOUT_WRITE: assert property ($rose(test_pin_oe) |-> $past(avs_write, 2))
    else $error("test pin enabled without a register write");
endmodule
bind gftc_top gftc_props i_gftc_props (.clk, .rst, .avs_read, .avs_write, .avs_waitrequest, .rx_frame_end,
  .rx_frame_len, .short_frame_done, .short_frame_flag, .dma_valid, .dma_data, .dma_is_data_section,
  .dma_out_data, .vec_req, .vec_queue_valid, .tx_chan_req, .tx_loop_valid, .test_pin_oe);
`default_nettype wire

// *** tb/test_global_frame_and_test_config.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_global_frame_and_test_config;
  import gftc_pkg::*;
  localparam int NP = 28;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, irq, free_pool_valid, rx_frame_end, rx_frame_crc32;
  logic [7:0] avs_address, rx_chan_data, tx_loop_data, rx_chan_id, tx_chan_id;
  logic [31:0] avs_writedata, avs_readdata, dma_data, dma_out_data, rdat;
  logic [3:0] avs_byteenable;
  logic [15:0] free_pool_count, rx_frame_len;
  logic short_frame_done, short_frame_flag, dma_valid, dma_is_data_section, dma_out_valid;
  logic vec_req, vec_is_port, vec_queue_valid, test_pin_in, test_pin_out, test_pin_oe;
  logic [2:0] vec_queue;
  logic [NP-1:0] port_pin_in, port_out_int, port_oe_int, port_pin_out, port_pin_oe;
  logic port0_tx_clk_in, port0_unchannelized, tx_clock_out_pin, tx_clock_out_pin_oe;
  logic rx_chan_valid, tx_chan_req, tx_loop_valid;
  int fails = 0;
  int total_checks = 0;
  int lim;

  gftc_top #(.NUM_PORTS(NP)) i_gftc_top (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .free_pool_valid, .free_pool_count, .rx_frame_end,
    .rx_frame_len, .rx_frame_crc32, .short_frame_done, .short_frame_flag, .dma_valid, .dma_data,
    .dma_is_data_section, .dma_out_valid, .dma_out_data, .vec_req, .vec_is_port, .vec_queue_valid, .vec_queue,
    .port_pin_in, .port_out_int, .port_oe_int, .port_pin_out, .port_pin_oe, .test_pin_in, .test_pin_out,
    .test_pin_oe, .port0_tx_clk_in, .port0_unchannelized, .tx_clock_out_pin, .tx_clock_out_pin_oe,
    .rx_chan_valid, .rx_chan_id, .rx_chan_data, .tx_chan_req, .tx_chan_id, .tx_loop_valid, .tx_loop_data);

  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // the request is held until an edge samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register", e, rdat);
  endtask
  task automatic frame(input int len, input logic c, input logic e);
    @(posedge clk);
    rx_frame_end <= 1'b1;
    rx_frame_len <= 16'(len);
    rx_frame_crc32 <= c;
    @(posedge clk);
    rx_frame_end <= 1'b0;
    @(negedge clk);
    chk("frame done", 1, short_frame_done);
    chk("short flag", e, short_frame_flag);
  endtask
  task automatic pool(input logic [15:0] n);
    @(posedge clk);
    free_pool_valid <= 1'b1;
    free_pool_count <= n;
    @(posedge clk);
    free_pool_valid <= 1'b0;
  endtask
  task automatic dma(input logic [31:0] d, input logic s, input logic [31:0] e);
    @(posedge clk);
    dma_valid <= 1'b1;
    dma_data <= d;
    dma_is_data_section <= s;
    @(posedge clk);
    dma_valid <= 1'b0;
    @(negedge clk);
    chk("dma valid", 1, dma_out_valid);
    chk("dma word", e, dma_out_data);
  endtask
  task automatic vec(input logic p, input logic [2:0] e);
    @(posedge clk);
    vec_req <= 1'b1;
    vec_is_port <= p;
    @(posedge clk);
    vec_req <= 1'b0;
    @(negedge clk);
    chk("queue", {28'h0, 1'b1, e}, {28'h0, vec_queue_valid, vec_queue});
  endtask
  task automatic chan(input logic tx, input logic [7:0] id, input logic [7:0] d);
    @(posedge clk);
    rx_chan_valid <= !tx;
    tx_chan_req <= tx;
    rx_chan_id <= id;
    tx_chan_id <= id;
    rx_chan_data <= d;
    @(posedge clk);
    rx_chan_valid <= 1'b0;
    tx_chan_req <= 1'b0;
    @(negedge clk);
    if (tx) chk("loop byte", {1'b1, d}, {tx_loop_valid, tx_loop_data});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done;
  end
  initial begin
    {rst, avs_read, avs_write, free_pool_valid, rx_frame_end, rx_frame_crc32, dma_valid} = 7'h01 << 6;
    {avs_address, avs_writedata, avs_byteenable, free_pool_count, rx_frame_len} = '0;
    {dma_data, dma_is_data_section, vec_req, vec_is_port, port_out_int, port_oe_int} = '0;
    {rx_chan_valid, tx_chan_req, rx_chan_id, tx_chan_id, rx_chan_data} = '0;
    port_pin_in = NP'(8);
    test_pin_in = 1'b1;
    port0_tx_clk_in = 1'b1;
    port0_unchannelized = 1'b1;
    avs_byteenable = 4'hF;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rc(8'h44, 32'h0000_0000);
    rc(8'h70, 32'h0000_FFFF);
    rc(8'h10, 32'h0000_0000);
    wr(8'h44, 32'hFFFF_FFFF);
    rc(8'h44, 32'h7760_9FFF);
    wr(8'h44, 32'h5200_0000);
    vec(1'b0, 3'h5);
    vec(1'b1, 3'h2);
    wr(8'h78, 32'h0000_0002);
    for (int s = 0; s < 2; s++) begin
      wr(8'h40, 32'(s));
      for (int c = 0; c < 2; c++) begin
        lim = s ? (c ? 4 : 2) : (c ? 6 : 4);
        frame(lim - 1, c[0], 1'b1);
        frame(lim, c[0], 1'b0);
      end
    end
    repeat (2) @(negedge clk);
    chk("irq", 1, irq);
    wr(8'h74, 32'h0000_0002);
    repeat (2) @(negedge clk);
    chk("irq", 0, irq);
    wr(8'h78, 32'h0000_0000);
    frame(0, 1'b0, 1'b1);
    repeat (2) @(negedge clk);
    chk("irq", 0, irq);
    wr(8'h40, 32'h0000_0000);
    pool(16'h0064);
    rc(8'h70, 32'h0000_0064);
    pool(16'h00C8);
    rc(8'h70, 32'h0000_0064);
    wr(8'h70, 32'h0000_0032);
    wr(8'h40, 32'h0000_0002);
    pool(16'h003C);
    rc(8'h74, 32'h0000_0002);
    pool(16'h0028);
    rc(8'h74, 32'h0000_0003);
    wr(8'h78, 32'h0000_0001);
    repeat (2) @(negedge clk);
    chk("irq", 1, irq);
    wr(8'h74, 32'h0000_0003);
    rc(8'h74, 32'h0000_0000);
    wr(8'h40, 32'h0000_0004);
    dma(32'h1122_3344, 1'b1, 32'h4433_2211);
    dma(32'h1122_3344, 1'b0, 32'h1122_3344);
    wr(8'h40, 32'h0000_0000);
    dma(32'h1122_3344, 1'b1, 32'h1122_3344);
    // other ports drive from inside; port 3 is switched off by software for the breakout
    port_oe_int <= ~NP'(8);
    wr(8'h44, 32'h0060_0300);
    repeat (5) @(negedge clk);
    chk("test out", 2'b11, {test_pin_oe, test_pin_out});
    chk("port 3 out", 2'b11, {port_pin_oe[3], port_pin_out[3]});
    chk("clock oe", 0, tx_clock_out_pin_oe);
    wr(8'h44, 32'h0060_0000);
    repeat (3) @(negedge clk);
    chk("clock oe", 1, tx_clock_out_pin_oe);
    wr(8'h44, 32'h0000_0000);
    repeat (5) @(negedge clk);
    chk("clock pin", 2'b11, {tx_clock_out_pin_oe, tx_clock_out_pin});
    chk("test oe", 0, test_pin_oe);
    chk("port 3 oe", 0, port_pin_oe[3]);
    chk("port 4 oe", 1, port_pin_oe[4]);
    port0_unchannelized <= 1'b0;
    repeat (3) @(negedge clk);
    chk("clock pin", 2'b10, {tx_clock_out_pin_oe, tx_clock_out_pin});
    wr(8'h44, 32'h0000_8007);
    chan(1'b0, 8'h07, 8'hA5);
    chan(1'b1, 8'h07, 8'hA5);
    chan(1'b1, 8'h07, GFTC_LOOP_IDLE);
    test_done;
  end
endmodule
`default_nettype wire
